// ### hdl/mrc_pkg.sv
// Constants for the module reset controller: pad indices, reset pad states,
// filter and hold times. Assumes a single 125 MHz clock drives the whole block.
package mrc_pkg;
  // Clock
  localparam int unsigned CLK_PERIOD_NS = 8;
  // External reset filter: least time before reset, latest time allowed
  localparam int unsigned EXT_MIN_NS = 1_500_000;
  localparam int unsigned EXT_MAX_NS = 4_000_000;
  localparam int unsigned EXT_MIN_CYCLES = (EXT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EXT_MAX_CYCLES = EXT_MAX_NS / CLK_PERIOD_NS;
  // Least low time on the serial receive line taken as a break
  localparam int unsigned BREAK_MIN_NS = 100_000;
  localparam int unsigned BREAK_MIN_CYCLES = (BREAK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Hold count reloaded while a source is on; the merged reset stays on HOLD_CYCLES + 1 cycles after the last source goes away
  localparam int unsigned HOLD_CYCLES = 16;
  localparam int unsigned HOLD_W = 5;
  // Width of the low-time counters and of the watchdog counter
  localparam int unsigned CNT_W = 20;
  localparam int unsigned WDOG_W = 32;
  // Pad indices
  localparam int unsigned NUM_PADS = 21;
  localparam int unsigned PAD_GIO_LO = 0;
  localparam int unsigned PAD_GIO_HI = 5;
  localparam int unsigned PAD_VOICE_TX = 6;
  localparam int unsigned PAD_VOICE_RX = 7;
  localparam int unsigned PAD_VOICE_SYNC = 8;
  localparam int unsigned PAD_VOICE_CLK = 9;
  localparam int unsigned PAD_UART_TX = 10;
  localparam int unsigned PAD_UART_RX = 11;
  localparam int unsigned PAD_UART_RTS = 12;
  localparam int unsigned PAD_UART_CTS = 13;
  localparam int unsigned PAD_USB_P = 14;
  localparam int unsigned PAD_USB_M = 15;
  localparam int unsigned PAD_SPI_SEL = 16;
  localparam int unsigned PAD_SPI_CLK = 17;
  localparam int unsigned PAD_SPI_MOSI = 18;
  localparam int unsigned PAD_SPI_MISO = 19;
  localparam int unsigned PAD_AUX = 20;
  // Pad states held during reset
  localparam logic [20:0] RST_OE_MASK = 21'h100000;
  localparam logic [20:0] RST_OUT_VAL = 21'h000000;
  localparam logic [20:0] RST_PU_MASK = 21'h001400;
  localparam logic [20:0] RST_PD_MASK = 21'h0febff;
  // Reset cause bit positions
  localparam int unsigned CAUSE_POR = 0;
  localparam int unsigned CAUSE_EXT = 1;
  localparam int unsigned CAUSE_BRK = 2;
  localparam int unsigned CAUSE_WDOG = 3;
endpackage

// ### hdl/mrc_hold_det.sv
// Low-time detector: flags a level that has stayed active for a whole threshold.
// Assumes the level is already synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module mrc_hold_det #(
  parameter int unsigned CNT_W = 20
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Level under watch and its threshold
  input wire logic level_active,
  input wire logic [CNT_W-1:0] threshold,
  // Detection
  output logic detected_r
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic detected_nxt;

  // Count consecutive active cycles, restart on any inactive cycle
  always_comb
  begin
    cnt_nxt = '0;
    if (level_active && cnt_r != threshold)
    begin
      cnt_nxt = cnt_r + 1'b1;
    end
    else if (level_active)
    begin
      cnt_nxt = cnt_r;
    end
    detected_nxt = level_active && (cnt_nxt == threshold);
  end

  // Register count and flag
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      detected_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      detected_r <= detected_nxt;
    end
  end
endmodule
`default_nettype wire

// ### hdl/mrc_top.sv
// Module reset controller: merges power-on, external pin, serial break and
// watchdog into one reset and forces the pads into their safe states.
// Assumes all inputs are synchronous to clock; pad cells apply oe, out and pulls.
`timescale 1ns/1ps
`default_nettype none
module mrc_top
  import mrc_pkg::*;
#(
  parameter int unsigned EXT_FILT_CYCLES = mrc_pkg::EXT_MIN_CYCLES,
  parameter int unsigned BREAK_CYCLES = mrc_pkg::BREAK_MIN_CYCLES
) (
  // Clock and controller reset
  input wire logic clock,
  input wire logic rst,
  // Reset sources
  input wire logic external_reset_n,
  input wire logic por_active,
  input wire logic uart_rx_level,
  // Watchdog set-up from software
  input wire logic wdog_enable,
  input wire logic wdog_kick,
  input wire logic [mrc_pkg::WDOG_W-1:0] wdog_limit,
  // Pad requests from the functional logic
  input wire logic [mrc_pkg::NUM_PADS-1:0] core_oe,
  input wire logic [mrc_pkg::NUM_PADS-1:0] core_out,
  input wire logic [mrc_pkg::NUM_PADS-1:0] core_pu,
  input wire logic [mrc_pkg::NUM_PADS-1:0] core_pd,
  // Pad controls
  output logic [mrc_pkg::NUM_PADS-1:0] pad_oe_r,
  output logic [mrc_pkg::NUM_PADS-1:0] pad_out_r,
  output logic [mrc_pkg::NUM_PADS-1:0] pad_pu_r,
  output logic [mrc_pkg::NUM_PADS-1:0] pad_pd_r,
  // Merged reset and its cause
  output logic sys_reset_r,
  output logic [3:0] reset_cause_r
);
  import mrc_pkg::*;

  typedef enum logic [0:0] {
    MRC_RUN = 1'b0,
    MRC_RESET = 1'b1
  } mrc_state_e;

  localparam logic [CNT_W-1:0] EXT_THR = CNT_W'(EXT_FILT_CYCLES);
  localparam logic [CNT_W-1:0] BRK_THR = CNT_W'(BREAK_CYCLES);
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYCLES);

  logic ext_det;
  logic brk_det;
  logic [3:0] src_vec;
  logic src_any;
  mrc_state_e state_r;
  mrc_state_e state_nxt;
  logic [HOLD_W-1:0] hold_r;
  logic [HOLD_W-1:0] hold_nxt;
  logic sys_reset_nxt;
  logic [3:0] cause_nxt;
  logic [WDOG_W-1:0] wd_cnt_r;
  logic [WDOG_W-1:0] wd_cnt_nxt;
  logic wd_exp_r;
  logic wd_exp_nxt;
  logic [NUM_PADS-1:0] pad_oe_nxt;
  logic [NUM_PADS-1:0] pad_out_nxt;
  logic [NUM_PADS-1:0] pad_pu_nxt;
  logic [NUM_PADS-1:0] pad_pd_nxt;

  // Pin filter: only a low lasting the full filter time counts
  mrc_hold_det #(
    .CNT_W(CNT_W)
  ) u_ext_filt (
    .clock(clock),
    .rst(rst),
    .level_active(~external_reset_n),
    .threshold(EXT_THR),
    .detected_r(ext_det)
  );

  // Break detector: receive line held low beyond a character time
  mrc_hold_det #(
    .CNT_W(CNT_W)
  ) u_brk_det (
    .clock(clock),
    .rst(rst),
    .level_active(~uart_rx_level),
    .threshold(BRK_THR),
    .detected_r(brk_det)
  );

  // Source collection
  always_comb
  begin
    src_vec = '0;
    src_vec[CAUSE_POR] = por_active;
    src_vec[CAUSE_EXT] = ext_det;
    src_vec[CAUSE_BRK] = brk_det;
    src_vec[CAUSE_WDOG] = wd_exp_r;
    src_any = |src_vec;
  end

  // Watchdog: counts since the last kick, cleared while reset is on
  always_comb
  begin
    wd_cnt_nxt = wd_cnt_r;
    wd_exp_nxt = 1'b0;
    if (sys_reset_r || !wdog_enable || wdog_kick)
    begin
      wd_cnt_nxt = '0;
    end
    else if (wd_cnt_r != wdog_limit)
    begin
      wd_cnt_nxt = wd_cnt_r + 1'b1;
    end
    else
    begin
      wd_exp_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wd_cnt_r <= '0;
      wd_exp_r <= 1'b0;
    end
    else
    begin
      wd_cnt_r <= wd_cnt_nxt;
      wd_exp_r <= wd_exp_nxt;
    end
  end

  // Merged reset: on at once with any source, off after a short hold
  always_comb
  begin
    state_nxt = state_r;
    hold_nxt = hold_r;
    cause_nxt = reset_cause_r;
    unique case (state_r)
      MRC_RUN:
      begin
        if (src_any)
        begin
          state_nxt = MRC_RESET;
          hold_nxt = HOLD_LOAD;
          cause_nxt = src_vec; // New reset, fresh cause
        end
      end
      MRC_RESET:
      begin
        cause_nxt = reset_cause_r | src_vec;
        if (src_any)
        begin
          hold_nxt = HOLD_LOAD;
        end
        else if (hold_r != '0)
        begin
          hold_nxt = hold_r - 1'b1;
        end
        else
        begin
          state_nxt = MRC_RUN;
        end
      end
    endcase
    sys_reset_nxt = (state_nxt == MRC_RESET);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_r <= MRC_RESET;
      hold_r <= HOLD_LOAD;
      reset_cause_r <= 4'h0;
      sys_reset_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      reset_cause_r <= cause_nxt;
      sys_reset_r <= sys_reset_nxt;
    end
  end

  // Pad states: safe pattern in reset, functional requests otherwise
  always_comb
  begin
    if (sys_reset_nxt)
    begin
      pad_oe_nxt = RST_OE_MASK;
      pad_out_nxt = RST_OUT_VAL;
      pad_pu_nxt = RST_PU_MASK;
      pad_pd_nxt = RST_PD_MASK;
    end
    else
    begin
      pad_oe_nxt = core_oe;
      pad_out_nxt = core_out;
      pad_pu_nxt = core_pu;
      pad_pd_nxt = core_pd;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pad_oe_r <= RST_OE_MASK;
      pad_out_r <= RST_OUT_VAL;
      pad_pu_r <= RST_PU_MASK;
      pad_pd_r <= RST_PD_MASK;
    end
    else
    begin
      pad_oe_r <= pad_oe_nxt;
      pad_out_r <= pad_out_nxt;
      pad_pu_r <= pad_pu_nxt;
      pad_pd_r <= pad_pd_nxt;
    end
  end
endmodule
`default_nettype wire

// ### bench/mrc_checker.sv
// Checker for the reset controller, bound to the top module's ports.
// Assumes one clock and the synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module mrc_checker
  import mrc_pkg::*;
#(
  parameter int unsigned EXT_FILT_CYCLES = 20
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Sources and pad requests
  input wire logic external_reset_n,
  input wire logic por_active,
  input wire logic [mrc_pkg::NUM_PADS-1:0] core_oe,
  // Watched outputs
  input wire logic [mrc_pkg::NUM_PADS-1:0] pad_oe_r,
  input wire logic [mrc_pkg::NUM_PADS-1:0] pad_out_r,
  input wire logic [mrc_pkg::NUM_PADS-1:0] pad_pu_r,
  input wire logic [mrc_pkg::NUM_PADS-1:0] pad_pd_r,
  input wire logic sys_reset_r,
  input wire logic [3:0] reset_cause_r
);
  logic [CNT_W-1:0] low_cnt_r;
  logic [CNT_W-1:0] low_cnt_nxt;
  // Counts consecutive low samples of the pin
  always_comb low_cnt_nxt = external_reset_n ? '0 : low_cnt_r + 20'h00001;
  always_ff @(posedge clock) low_cnt_r <= rst ? '0 : low_cnt_nxt;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_por_enters: assert property (por_active |=> sys_reset_r && reset_cause_r[CAUSE_POR])
    else $error("power-on did not reset");
  a_safe_drive: assert property (sys_reset_r |-> pad_oe_r == RST_OE_MASK
    && pad_out_r == RST_OUT_VAL)
    else $error("pads driven in reset");
  a_safe_pull_down: assert property (sys_reset_r |-> pad_pd_r == RST_PD_MASK)
    else $error("pull-downs wrong in reset");
  a_safe_pull_up: assert property (sys_reset_r |-> pad_pu_r == RST_PU_MASK)
    else $error("pull-ups wrong in reset");
  a_pads_follow: assert property (!sys_reset_r |-> pad_oe_r == $past(core_oe))
    else $error("pads not following core");
  a_glitch_ignored: assert property (($fell(external_reset_n)
    && !sys_reset_r && !por_active) ##1 (!external_reset_n)[*8] |-> !sys_reset_r)
    else $error("short pin low caused reset");
  a_pin_deadline: assert property (low_cnt_r >= EXT_FILT_CYCLES + 2 |-> sys_reset_r)
    else $error("pin reset late");
  a_hold_merged: assert property (por_active ##1 (!por_active)[*8] |-> sys_reset_r)
    else $error("reset released early");
endmodule
bind mrc_top mrc_checker #(.EXT_FILT_CYCLES(EXT_FILT_CYCLES)) u_chk (.clock, .rst,
  .external_reset_n, .por_active, .core_oe, .pad_oe_r, .pad_out_r, .pad_pu_r, .pad_pd_r,
  .sys_reset_r, .reset_cause_r);
`default_nettype wire

// ### bench/mrc_board.sv
// Board model: reset pin held at power-up, host sending breaks.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module mrc_board (
  // Clock and supply state
  input wire logic clock,
  input wire logic supplies_ok,
  // Lines into the block
  output logic external_reset_n,
  output logic uart_rx_level
);
  // Pin low from power-up until supplies settle
  initial external_reset_n = 1'b0;
  initial uart_rx_level = 1'b1;
  always @(posedge supplies_ok) external_reset_n = 1'b1;
  // Reset request held low for n cycles
  task pin_low(input int n);
    @(posedge clock);
    #1 external_reset_n = 1'b0;
    repeat (n) @(posedge clock);
    #1 external_reset_n = 1'b1;
  endtask
  // Break on the serial line for n cycles
  task rx_break(input int n);
    @(posedge clock);
    #1 uart_rx_level = 1'b0;
    repeat (n) @(posedge clock);
    #1 uart_rx_level = 1'b1;
  endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Testbench for the reset controller with shortened filter counts.
// Assumes the board model drives the pin and serial line.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mrc_pkg::*;
  localparam int FILT = 20;
  localparam int BRK = 10;
  logic clock = 0;
  logic rst = 1;
  logic por_active = 0;
  logic supplies_ok = 0;
  logic wdog_enable = 0;
  logic wdog_kick = 0;
  logic [WDOG_W-1:0] wdog_limit = 32'h00000032;
  logic [NUM_PADS-1:0] core_oe = 21'h0aaaaa;
  logic [NUM_PADS-1:0] core_out = 21'h155555;
  logic [NUM_PADS-1:0] core_pu = 21'h00f00f;
  logic [NUM_PADS-1:0] core_pd = 21'h0f0ff0;
  logic [NUM_PADS-1:0] pad_oe_r, pad_out_r, pad_pu_r, pad_pd_r;
  logic sys_reset_r;
  logic [3:0] reset_cause_r;
  wire logic external_reset_n;
  wire logic uart_rx_level;
  int n_errors = 0;
  int checks = 0;
  int n;
  always #4 clock = ~clock;
  mrc_board brd (.clock, .supplies_ok, .external_reset_n, .uart_rx_level);
  mrc_top #(.EXT_FILT_CYCLES(FILT), .BREAK_CYCLES(BRK)) dut (.clock, .rst, .external_reset_n,
    .por_active, .uart_rx_level, .wdog_enable, .wdog_kick, .wdog_limit, .core_oe, .core_out,
    .core_pu, .core_pd, .pad_oe_r, .pad_out_r, .pad_pu_r, .pad_pd_r, .sys_reset_r,
    .reset_cause_r);
  task step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task chk_pads(input logic r);
    chk("pad_oe", r ? RST_OE_MASK : core_oe, pad_oe_r);
    chk("pad_out", r ? RST_OUT_VAL : core_out, pad_out_r);
    chk("pad_pu", r ? RST_PU_MASK : core_pu, pad_pu_r);
    chk("pad_pd", r ? RST_PD_MASK : core_pd, pad_pd_r);
  endtask
  // Bounded wait for the merged reset to reach v, counting edges
  task wait_level(input logic v, input int lim);
    n = 0;
    while (sys_reset_r !== v && n < lim)
    begin
      step(1);
      n++;
    end
    chk("sys_reset", v, sys_reset_r);
  endtask
  // Power-up with the pin held low, then release
  task t_power_up;
    step(30);
    chk("cause", 4'h2, reset_cause_r);
    chk_pads(1);
    supplies_ok = 1;
    wait_level(0, 60);
    chk_pads(0);
  endtask
  // New pad requests reach the pads one edge later, then a pin low shorter than the filter
  task t_glitch;
    core_oe = 21'h055555;
    core_out = 21'h0aaaaa;
    core_pu = 21'h000ff0;
    core_pd = 21'h10f00f;
    step(1);
    chk_pads(0);
    brd.pin_low(FILT - 5);
    step(25);
    chk("sys_reset", 0, sys_reset_r);
  endtask
  // Long pin request and its delay
  task t_pin;
    fork
      brd.pin_low(FILT + 20);
      begin
        step(1);
        wait_level(1, FILT + 10);
      end
    join
    chk("ext_delay_ok", 1, n >= FILT && n <= FILT + 2);
    chk("cause", 4'h2, reset_cause_r);
    wait_level(0, 60);
  endtask
  // Serial break reset
  task t_break;
    brd.rx_break(BRK + 5);
    chk("sys_reset", 1, sys_reset_r);
    chk("cause", 4'h4, reset_cause_r);
    wait_level(0, 60);
  endtask
  // Watchdog kicked in time, then left to expire
  task t_wdog;
    wdog_enable = 1;
    repeat (4)
    begin
      step(30);
      wdog_kick = 1;
      step(1);
      wdog_kick = 0;
    end
    chk("sys_reset", 0, sys_reset_r);
    wait_level(1, 80);
    chk("cause", 4'h8, reset_cause_r);
    wdog_enable = 0;
    wait_level(0, 60);
  endtask
  // Power-on with a break while reset holds
  task t_por;
    por_active = 1;
    brd.rx_break(BRK + 5);
    chk("cause", 4'h5, reset_cause_r);
    chk_pads(1);
    por_active = 0;
    wait_level(0, 40);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    step(4);
    rst = 0;
    t_power_up;
    t_glitch;
    t_pin;
    t_break;
    t_wdog;
    t_por;
    wrap_up;
  end
  // Watchdog for a hung run
  initial
  begin
    #8000;
    #8000;
    n_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
